//--- bench/card_address_space_decode_test.sv
// Self-checking bench for the host socket controller.
// Assumes the card model and the checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module card_address_space_decode_test;
	typedef struct packed {
		csa_pkg::csa_space_t sp;
		logic [2:0]          ctl;
		logic [25:0]         a;
		logic [15:0]         wdat;
		logic [15:0]         rd;
		logic [15:0]         m;
		logic [3:0]          fl;
	} csa_row_t;
	localparam csa_pkg::csa_space_t CM = csa_pkg::SP_COMMON;
	localparam csa_pkg::csa_space_t AT = csa_pkg::SP_ATTR;
	localparam csa_pkg::csa_space_t IO = csa_pkg::SP_IO;
	// ctl is io mode, write, word; fl is refused, no ack, split, undefined
	localparam csa_row_t ROWS [14] = '{
		'{CM, 3'h3, 26'h4, 16'h1234, 16'h0, 16'h0, 4'h0}, '{CM, 3'h1, 26'h4, 16'h0, 16'h1234, 16'hFFFF, 4'h0},
		'{CM, 3'h2, 26'h7, 16'h00AB, 16'h0, 16'h0, 4'h0}, '{CM, 3'h1, 26'h6, 16'h0, 16'hAB00, 16'hFFFF, 4'h0},
		'{CM, 3'h0, 26'h7, 16'h0, 16'h00AB, 16'h00FF, 4'h0}, '{AT, 3'h0, 26'h0, 16'h0, 16'h0001, 16'h00FF, 4'h0},
		'{AT, 3'h0, 26'h4, 16'h0, 16'h0003, 16'h00FF, 4'h0}, '{AT, 3'h0, 26'h5, 16'h0, 16'h0, 16'h0, 4'h1},
		'{IO, 3'h1, 26'h300, 16'h0, 16'h0, 16'h0, 4'h8}, '{IO, 3'h5, 26'h300, 16'h0, 16'hC3A5, 16'hFFFF, 4'h0},
		'{IO, 3'h5, 26'h310, 16'h0, 16'h4B3C, 16'hFFFF, 4'h2}, '{IO, 3'h4, 26'h320, 16'h0, 16'h0, 16'h0, 4'h4},
		'{IO, 3'h4, 26'h400, 16'h0, 16'h0, 16'h0, 4'h8}, '{IO, 3'h7, 26'h302, 16'h5A5A, 16'h0, 16'h0, 4'h0}};
	logic                 clk;
	logic                 nrst;
	logic                 req_valid;
	logic                 req_ready;
	csa_pkg::csa_req_t    req;
	logic                 rsp_valid;
	csa_pkg::csa_rsp_t    rsp;
	logic                 card_present;
	logic                 card_reset_req;
	logic                 io_mode_req;
	logic                 irq_req;
	logic                 win_overlap;
	csa_pkg::csa_status_t status;
	csa_pkg::csa_pins_t   pins;
	logic [15:0]          data_in;
	logic                 ready_irq_pin;
	logic                 wp_wide_port_flag_n;
	logic [1:0]           battery_level_detect;
	logic                 input_port_ack_n;
	int                   mismatches = 0;
	int                   n_compared = 0;
	csa_row_t             r;
	int                   n;

	csa_host_socket dut_u (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.rsp_valid(rsp_valid), .rsp(rsp), .card_present(card_present), .card_reset_req(card_reset_req),
		.io_mode_req(io_mode_req), .win_base(26'h300), .win_mask(26'h3FFFF00), .win_overlap(win_overlap), .status(status),
		.pins(pins), .data_in(data_in), .ready_irq_pin(ready_irq_pin), .wp_wide_port_flag_n(wp_wide_port_flag_n),
		.battery_level_detect(battery_level_detect), .input_port_ack_n(input_port_ack_n));
	csa_card_model card_u (.clk(clk), .pins(pins), .cfg_io(io_mode_req), .irq_req(irq_req), .data_in(data_in),
		.ready_irq_pin(ready_irq_pin), .wp_wide_port_flag_n(wp_wide_port_flag_n),
		.battery_level_detect(battery_level_detect), .input_port_ack_n(input_port_ack_n));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic run_req(input csa_pkg::csa_req_t q);
		int k;
		k = 0;
		@(posedge clk);
		req <= q;
		req_valid <= 1'b1;
		do @(negedge clk); while (req_ready !== 1'b1 && ++k < 100);
		@(posedge clk);
		req_valid <= 1'b0;
		k = 0;
		do @(negedge clk); while (rsp_valid !== 1'b1 && ++k < 200);
		chk("rsp_valid", rsp_valid, 1'b1);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
	initial begin
		nrst = 1'b0;
		req_valid = 1'b0;
		req = '0;
		card_present = 1'b1;
		card_reset_req = 1'b0;
		io_mode_req = 1'b0;
		irq_req = 1'b0;
		win_overlap = 1'b0;
		repeat (3) @(negedge clk);
		chk("idle pins", {pins.oe_n, pins.we_n, pins.iord_n, pins.iowr_n, pins.reg_n, pins.data_oe}, 6'h3E);
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			r = ROWS[i];
			if (io_mode_req !== r.ctl[2]) begin
				@(posedge clk);
				io_mode_req <= r.ctl[2];
				n = 0;
				do @(negedge clk); while (status.mode_io !== r.ctl[2] && ++n < 20);
				chk("mode_io", status.mode_io, r.ctl[2]);
			end
			run_req('{r.sp, r.ctl[1], r.ctl[0], r.a, r.wdat});
			chk("rdata", rsp.rdata & r.m, r.rd);
			chk("flags", {rsp.refused, rsp.no_ack, rsp.split, rsp.undef}, r.fl);
		end
		// Overlapping window leaves the low lines to the card: no refusal, card stays silent
		@(posedge clk);
		win_overlap <= 1'b1;
		run_req('{IO, 1'b0, 1'b0, 26'h100, 16'h0});
		chk("overlap flags", {rsp.refused, rsp.no_ack}, 2'h1);
		chk("io status", {status.ready, status.wr_protect, status.battery, status.status_chg, status.speaker}, 6'h00);
		@(posedge clk);
		irq_req <= 1'b1;
		n = 0;
		do @(negedge clk); while (status.irq !== 1'b1 && ++n < 20);
		chk("irq", status.irq, 1'b1);
		@(posedge clk);
		card_reset_req <= 1'b1;
		io_mode_req <= 1'b0;
		n = 0;
		do @(negedge clk); while (status.ready !== 1'b1 && ++n < 20);
		chk("reset status", {status.mode_io, status.irq, status.ready, status.wr_protect, status.battery}, 6'h0A);
		chk("card_reset", {pins.card_reset, req_ready}, 2'h2);
		@(posedge clk);
		card_reset_req <= 1'b0;
		run_req('{IO, 1'b0, 1'b0, 26'h300, 16'h0});
		chk("refused", rsp.refused, 1'b1);
		@(posedge clk);
		card_present <= 1'b0;
		@(negedge clk);
		chk("no card ready", req_ready, 1'b0);
		@(posedge clk);
		card_present <= 1'b1;
		req <= '{CM, 1'b1, 1'b1, 26'h8, 16'h7777};
		req_valid <= 1'b1;
		repeat (12) @(posedge clk);
		nrst <= 1'b0;
		req_valid <= 1'b0;
		@(negedge clk);
		chk("reset strobes", {pins.we_n, pins.oe_n, pins.data_oe, status.mode_io}, 4'hC);
		@(posedge clk);
		nrst <= 1'b1;
		run_req('{CM, 1'b0, 1'b1, 26'h4, 16'h0});
		chk("after reset", rsp.rdata, 16'h1234);
		give_verdict();
	end
endmodule
bind csa_host_socket csa_host_socket_asserts chk_u (.clk(clk), .nrst(nrst), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .card_present(card_present),
	.card_reset_req(card_reset_req), .status(status), .pins(pins));
`default_nettype wire

//--- bench/csa_card_model.sv
// Behavioural card: common and attribute memory, two input ports.
// Assumes pins are sampled on clk and configuration comes as a level.
`timescale 1ns/1ps
`default_nettype none
module csa_card_model (
	input  wire logic               clk,                  // Bus clock
	input  wire csa_pkg::csa_pins_t pins,                 // Pins from socket
	input  wire logic               cfg_io,               // Host configured io
	input  wire logic               irq_req,              // Card wants service
	output logic [15:0]             data_in,              // Card data
	output logic                    ready_irq_pin,        // Ready or interrupt
	output logic                    wp_wide_port_flag_n,  // Write protect or wide flag
	output logic [1:0]              battery_level_detect, // Battery or status
	output logic                    input_port_ack_n      // Input acknowledge
);
	logic [15:0] mem [16];
	logic [15:0] last_r;
	logic [15:0] val;
	logic        io_r;
	logic        sel;
	logic        wide;
	logic        io_hit;
	logic        rd;
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
		last_r = 16'h0000;
		io_r = 1'b0;
	end
	assign sel = !(pins.even_byte_enable_n && pins.odd_byte_enable_n);
	assign wide = io_r && sel && pins.addr[9:4] == 6'h30;
	assign io_hit = io_r && sel && (pins.addr[9:4] == 6'h30 || pins.addr[9:4] == 6'h31);
	assign rd = sel && (!pins.oe_n || (io_hit && !pins.iord_n));
	always_comb begin
		if (io_hit) val = wide ? 16'hC3A5 : 16'h4B3C;
		else if (!pins.reg_n) val = {~last_r[7:0], pins.addr[8:1] ^ 8'h01};
		else val = mem[pins.addr[4:1]];
	end
	// Released bus toggles so stale data never matches
	assign data_in = rd ? val : ~last_r;
	assign input_port_ack_n = !(io_hit && !pins.iord_n);
	assign wp_wide_port_flag_n = io_r ? !wide : 1'b0;
	assign ready_irq_pin = io_r ? !irq_req : 1'b1;
	assign battery_level_detect = io_r ? 2'h3 : 2'h2;
	always @(posedge clk) begin
		last_r <= data_in;
		io_r <= !pins.card_reset && cfg_io;
		if (!pins.we_n && pins.reg_n && !pins.even_byte_enable_n) mem[pins.addr[4:1]][7:0] <= pins.data_out[7:0];
		if (!pins.we_n && pins.reg_n && !pins.odd_byte_enable_n) mem[pins.addr[4:1]][15:8] <= pins.data_out[15:8];
	end
endmodule
`default_nettype wire

//--- bench/csa_host_socket_asserts.sv
// Checker for the host socket controller, watching its ports only.
// Assumes one clock domain and the bind in the bench top file.
`timescale 1ns/1ps
`default_nettype none
module csa_host_socket_asserts (
	input wire logic                 clk,            // Bus clock
	input wire logic                 nrst,           // Async reset, active low
	input wire logic                 req_valid,      // Request offered
	input wire logic                 req_ready,      // Request taken
	input wire csa_pkg::csa_req_t    req,            // Request fields
	input wire logic                 rsp_valid,      // Answer pulse
	input wire csa_pkg::csa_rsp_t    rsp,            // Answer fields
	input wire logic                 card_present,   // Card inserted
	input wire logic                 card_reset_req, // Card held in reset
	input wire csa_pkg::csa_status_t status,         // Pin status
	input wire csa_pkg::csa_pins_t   pins            // Card pins
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic take;
	assign take = req_valid && req_ready;

	mem_cycle_len_a: assert property (take && req.space != csa_pkg::SP_IO |=> !rsp_valid[*8] ##[28:30] rsp_valid)
		else $error("memory cycle answer out of time");
	io_refused_a: assert property (take && req.space == csa_pkg::SP_IO && !status.mode_io |-> ##[1:3] rsp_valid && rsp.refused)
		else $error("io access not refused in memory mode");
	io_gate_a: assert property (!(pins.iord_n && pins.iowr_n) |-> status.mode_io)
		else $error("io strobe outside io mode");
	io_enable_a: assert property (!pins.iord_n || !pins.iowr_n |-> !pins.reg_n)
		else $error("io strobe without io enable");
	word_io_even_a: assert property (!pins.iord_n && !pins.even_byte_enable_n && !pins.odd_byte_enable_n |-> !pins.addr[0])
		else $error("word io with odd address");
	strobe_select_a: assert property (!pins.oe_n || !pins.we_n |-> !(pins.even_byte_enable_n && pins.odd_byte_enable_n) && pins.iord_n && pins.iowr_n)
		else $error("memory strobe without byte enable");
	reset_mode_a: assert property (card_reset_req |-> ##[1:2] !status.mode_io)
		else $error("card reset left io mode");
	no_card_a: assert property (!card_present || card_reset_req |-> !req_ready)
		else $error("request taken without usable card");
	mem_mode_pins_a: assert property (!status.mode_io |-> !status.irq && !status.status_chg && !status.speaker)
		else $error("io status shown in memory mode");
	io_mode_pins_a: assert property (status.mode_io |-> !status.ready && !status.wr_protect && status.battery == 2'h0)
		else $error("memory status shown in io mode");
endmodule
`default_nettype wire

//--- rtl/csa_host_socket.sv
// Host socket controller driving one removable card over the 16-bit card bus.
// Assumes card pins are synchronous to clk; the pad ring resolves data_out/data_oe.
`timescale 1ns/1ps
`default_nettype none
module csa_host_socket #(
	parameter int DEC_BITS = csa_pkg::OVL_DEC_BITS
) (
	input  wire logic                          clk,                  // 100 MHz clock
	input  wire logic                          nrst,                 // Async reset, active low
	// User request side
	input  wire logic                          req_valid,            // Request offered
	output logic                               req_ready,            // Request taken
	input  wire csa_pkg::csa_req_t             req,                  // Request fields
	output logic                               rsp_valid,            // One-cycle answer
	output csa_pkg::csa_rsp_t                  rsp,                  // Answer fields
	// Socket configuration and status
	input  wire logic                          card_present,         // Card inserted
	input  wire logic                          card_reset_req,       // Hold card in reset
	input  wire logic                          io_mode_req,          // Card configured for I/O
	input  wire logic [csa_pkg::ADDR_W-1:0]    win_base,             // I/O window base
	input  wire logic [csa_pkg::ADDR_W-1:0]    win_mask,             // I/O window mask
	input  wire logic                          win_overlap,          // Overlapping window
	output csa_pkg::csa_status_t               status,               // Pin status by mode
	// Card pins
	output csa_pkg::csa_pins_t                 pins,                 // Driven card pins
	input  wire logic [csa_pkg::DATA_W-1:0]    data_in,              // Data from card
	input  wire logic                          ready_irq_pin,        // Ready or interrupt request
	input  wire logic                          wp_wide_port_flag_n,  // Write protect or wide flag
	input  wire logic [1:0]                    battery_level_detect, // Battery or status/speaker
	input  wire logic                          input_port_ack_n      // Input port acknowledge
);

	typedef struct packed {
		csa_pkg::csa_fsm_t    fsm;
		logic [7:0]           cnt;
		csa_pkg::csa_req_t    req;
		logic                 split;
		logic                 second;
		logic                 mode_io;
		logic                 rsp_valid;
		csa_pkg::csa_rsp_t    rsp;
		csa_pkg::csa_status_t status;
		csa_pkg::csa_pins_t   pins;
	} csa_state_t;

	csa_state_t s_r;
	csa_state_t s_nxt;
	logic       win_hit;

	// ----------------------------------------
	// I/O window decode
	// ----------------------------------------
	csa_io_window #(
		.AW       (csa_pkg::ADDR_W),
		.DEC_BITS (DEC_BITS)
	) u_win (
		.addr    (req.addr),
		.base    (win_base),
		.mask    (win_mask),
		.overlap (win_overlap),
		.hit     (win_hit)
	);

	function automatic logic is_io(input csa_pkg::csa_req_t r);
		is_io = (r.space == csa_pkg::SP_IO);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp_valid = 1'b0;
		s_nxt.pins.card_reset = card_reset_req;

		// Mode falls back on removal or card reset
		if (!card_present || card_reset_req) begin
			s_nxt.mode_io = 1'b0;
		end else if (io_mode_req) begin
			s_nxt.mode_io = 1'b1;
		end

		// Shared pins take their meaning from the mode
		s_nxt.status.mode_io    = s_r.mode_io;
		s_nxt.status.ready      = !s_r.mode_io && ready_irq_pin;
		// Write protect level is active high, unlike the wide flag sharing the pin
		s_nxt.status.wr_protect = !s_r.mode_io && wp_wide_port_flag_n;
		s_nxt.status.battery    = s_r.mode_io ? 2'h0 : battery_level_detect;
		s_nxt.status.irq        = s_r.mode_io && !ready_irq_pin;
		s_nxt.status.status_chg = s_r.mode_io && !battery_level_detect[0];
		s_nxt.status.speaker    = s_r.mode_io && !battery_level_detect[1];

		case (s_r.fsm)
			csa_pkg::ST_IDLE: begin
				if (req_valid && req_ready) begin
					s_nxt.req    = req;
					s_nxt.split  = 1'b0;
					s_nxt.second = 1'b0;
					s_nxt.rsp    = '0;
					s_nxt.rsp.undef = (req.space == csa_pkg::SP_ATTR) && (req.word || req.addr[0]);
					if (is_io(req) && (!s_r.mode_io || !win_hit)) begin
						s_nxt.rsp.refused = 1'b1;
						s_nxt.fsm = csa_pkg::ST_DONE;
					end else begin
						s_nxt.pins.addr    = req.addr;
						s_nxt.pins.reg_n   = (req.space == csa_pkg::SP_COMMON);
						if (req.word) begin
							s_nxt.pins.addr[0]            = 1'b0;
							s_nxt.pins.even_byte_enable_n = 1'b0;
							s_nxt.pins.odd_byte_enable_n  = 1'b0;
						end else begin
							s_nxt.pins.even_byte_enable_n = req.addr[0];
							s_nxt.pins.odd_byte_enable_n  = !req.addr[0];
						end
						s_nxt.pins.data_out = req.addr[0] && !req.word ? {req.wdata[7:0], req.wdata[7:0]}
						                                               : req.wdata;
						s_nxt.pins.data_oe  = req.write;
						s_nxt.cnt = csa_pkg::SETUP_CYC;
						s_nxt.fsm = csa_pkg::ST_SETUP;
					end
				end
			end
			csa_pkg::ST_SETUP: begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01) begin
					// Narrow port seen on a word I/O cycle: run low byte first
					if (is_io(s_r.req) && s_r.req.word && !s_r.second && wp_wide_port_flag_n) begin
						s_nxt.split = 1'b1;
						s_nxt.rsp.split = 1'b1;
						s_nxt.pins.odd_byte_enable_n = 1'b1;
					end
					s_nxt.pins.oe_n   = !(!is_io(s_r.req) && !s_r.req.write);
					s_nxt.pins.we_n   = !(!is_io(s_r.req) && s_r.req.write);
					s_nxt.pins.iord_n = !(is_io(s_r.req) && !s_r.req.write);
					s_nxt.pins.iowr_n = !(is_io(s_r.req) && s_r.req.write);
					s_nxt.cnt = csa_pkg::STROBE_CYC;
					s_nxt.fsm = csa_pkg::ST_STROBE;
				end
			end
			csa_pkg::ST_STROBE: begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01) begin
					if (!s_r.req.write) begin
						if (!s_r.pins.even_byte_enable_n) begin
							s_nxt.rsp.rdata[7:0] = data_in[7:0];
						end
						if (!s_r.pins.odd_byte_enable_n) begin
							if (s_r.req.word) begin
								s_nxt.rsp.rdata[15:8] = data_in[15:8];
							end else begin
								s_nxt.rsp.rdata[7:0] = data_in[15:8];
							end
						end
						// Data captured with or without a card acknowledge; a missing one only sets no_ack
						if (is_io(s_r.req) && input_port_ack_n) begin
							s_nxt.rsp.no_ack = 1'b1;
						end
					end
					s_nxt.pins.oe_n   = 1'b1;
					s_nxt.pins.we_n   = 1'b1;
					s_nxt.pins.iord_n = 1'b1;
					s_nxt.pins.iowr_n = 1'b1;
					s_nxt.cnt = csa_pkg::HOLD_CYC;
					s_nxt.fsm = csa_pkg::ST_HOLD;
				end
			end
			csa_pkg::ST_HOLD: begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01) begin
					if (s_r.split && !s_r.second) begin
						// Second half: odd byte on the high lane
						s_nxt.second = 1'b1;
						s_nxt.pins.addr[0]            = 1'b1;
						s_nxt.pins.even_byte_enable_n = 1'b1;
						s_nxt.pins.odd_byte_enable_n  = 1'b0;
						s_nxt.cnt = csa_pkg::SETUP_CYC;
						s_nxt.fsm = csa_pkg::ST_SETUP;
					end else begin
						s_nxt.pins.even_byte_enable_n = 1'b1;
						s_nxt.pins.odd_byte_enable_n  = 1'b1;
						s_nxt.pins.reg_n   = 1'b1;
						s_nxt.pins.data_oe = 1'b0;
						s_nxt.fsm = csa_pkg::ST_DONE;
					end
				end
			end
			csa_pkg::ST_DONE: begin
				s_nxt.rsp_valid = 1'b1;
				s_nxt.fsm = csa_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.fsm = csa_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.fsm <= csa_pkg::ST_IDLE;
			s_r.pins.even_byte_enable_n <= 1'b1;
			s_r.pins.odd_byte_enable_n  <= 1'b1;
			s_r.pins.oe_n   <= 1'b1;
			s_r.pins.we_n   <= 1'b1;
			s_r.pins.iord_n <= 1'b1;
			s_r.pins.iowr_n <= 1'b1;
			s_r.pins.reg_n  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign req_ready = (s_r.fsm == csa_pkg::ST_IDLE) && card_present && !card_reset_req;
	assign rsp_valid = s_r.rsp_valid;
	assign rsp       = s_r.rsp;
	assign status    = s_r.status;
	assign pins      = s_r.pins;
endmodule
`default_nettype wire

//--- rtl/csa_io_window.sv
// Host-side I/O window decoder for one socket.
// Assumes base and mask are held stable while accesses run.
`timescale 1ns/1ps
`default_nettype none
module csa_io_window #(
	parameter int AW       = 26,
	parameter int DEC_BITS = 10
) (
	input  wire logic [AW-1:0] addr,     // Address on the bus
	input  wire logic [AW-1:0] base,     // Window base
	input  wire logic [AW-1:0] mask,     // Bits compared, 1 = compare
	input  wire logic          overlap,  // 1 = card decodes low lines
	output logic               hit       // Address selects this socket
);
	logic [AW-1:0] miss;

	// ----------------------------------------
	// Per-line compare
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < AW; i++) begin : g_bit
			// Low lines left to the card in overlap mode
			if (i < DEC_BITS) begin : g_low
				assign miss[i] = !overlap && mask[i] && (addr[i] != base[i]);
			end else begin : g_high
				assign miss[i] = mask[i] && (addr[i] != base[i]);
			end
		end
	endgenerate

	assign hit = (miss == '0);
endmodule
`default_nettype wire

//--- rtl/csa_pkg.sv
// Shared types and constants for the card-bus host socket controller.
// Assumes a single 100 MHz clock and a card bus of 26 address and 16 data lines.
package csa_pkg;

	// ----------------------------------------
	// Bus geometry and capacity
	// ----------------------------------------
	localparam int ADDR_W       = 26;
	localparam int DATA_W       = 16;
	// Common memory address bits reachable per paging scheme
	localparam int CM_BITS_NONE = 26;
	localparam int CM_BITS_8X1  = 34;
	localparam int CM_BITS_8X2  = 33;
	localparam int CM_BITS_8X4  = 32;
	localparam int CM_BITS_16X1 = 42;
	localparam int CM_BITS_16X2 = 41;
	localparam int CM_BITS_16X4 = 40;
	localparam int CM_BITS_COR  = 32;
	// Lines the card decodes in an overlapping window
	localparam int OVL_DEC_BITS = 10;

	// ----------------------------------------
	// Cycle timing
	// ----------------------------------------
	localparam int CLK_NS     = 10;
	localparam int SETUP_NS   = 30;
	localparam int STROBE_NS  = 300;
	localparam int HOLD_NS    = 20;
	localparam logic [7:0] SETUP_CYC  = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] HOLD_CYC   = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SP_COMMON = 2'h0,
		SP_ATTR   = 2'h1,
		SP_IO     = 2'h2
	} csa_space_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETUP  = 3'h1,
		ST_STROBE = 3'h2,
		ST_HOLD   = 3'h3,
		ST_DONE   = 3'h4
	} csa_fsm_t;

	typedef struct packed {
		csa_space_t          space;
		logic                write;
		logic                word;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
	} csa_req_t;

	typedef struct packed {
		logic [DATA_W-1:0]   rdata;
		logic                refused;
		logic                no_ack;
		logic                split;
		logic                undef;
	} csa_rsp_t;

	typedef struct packed {
		logic                mode_io;
		logic                ready;
		logic                wr_protect;
		logic [1:0]          battery;
		logic                irq;
		logic                status_chg;
		logic                speaker;
	} csa_status_t;

	typedef struct packed {
		logic [ADDR_W-1:0]   addr;
		logic                even_byte_enable_n;
		logic                odd_byte_enable_n;
		logic                oe_n;
		logic                we_n;
		logic                iord_n;
		logic                iowr_n;
		logic                reg_n;
		logic                card_reset;
		logic [DATA_W-1:0]   data_out;
		logic                data_oe;
	} csa_pins_t;

endpackage
